// ===== rtl/adcseq_consts.vh
// Functional notes
// - Software trigger: conversion starts when start flag changes to one.
// - External trigger: flag one plus falling trigger edge starts or retriggers.
// - No sample-hold: 49 cycles at 8 bits, 59 at 10 bits.
// - Sample-hold: 28 cycles at 8 bits, 33 at 10 bits.
// - Result stored in the register of the converted channel.
// - 10-bit result: low 8 bits in even byte, upper bits odd byte.
// - Reference-connect bit 5 cleared disconnects the resistor ladder.
// - Five modes: one-shot, repeat, single sweep, repeat sweep 0 and 1.
// - Ten inputs: eight standard channels plus two extended inputs.
// - Conversion clock is base clock, divided by two or by four.
// - Three-bit channel select, 000 channel zero to 111 channel seven.
// - Mode field: 00 one-shot, 01 repeat, 10 sweep, 11 repeat sweep.
// - Start flag reads one while conversion enabled, zero when disabled.
`ifndef ADCSEQ_CONSTS_VH
`define ADCSEQ_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCSEQ_OFF_CTRL0    8'h00
`define ADCSEQ_OFF_CTRL1    8'h04
`define ADCSEQ_OFF_STATUS   8'h08
`define ADCSEQ_OFF_INT_STAT 8'h10
`define ADCSEQ_OFF_INT_CLR  8'h14
`define ADCSEQ_OFF_INT_EN   8'h18
`define ADCSEQ_OFF_RES0     8'h20
`define ADCSEQ_NUM_CH       4'h0a

// ----------------------------------------------------------------
// Control 0 fields
// ----------------------------------------------------------------
`define ADCSEQ_CH_LSB       0
`define ADCSEQ_CH_MSB       2
`define ADCSEQ_MD_LSB       3
`define ADCSEQ_MD_MSB       4
`define ADCSEQ_TRG_BIT      5
`define ADCSEQ_ST_BIT       6

// ----------------------------------------------------------------
// Control 1 fields
// ----------------------------------------------------------------
`define ADCSEQ_RES10_BIT    0
`define ADCSEQ_SH_BIT       1
`define ADCSEQ_SWP1_BIT     2
`define ADCSEQ_EXT_LSB      3
`define ADCSEQ_EXT_MSB      4
`define ADCSEQ_VREF_BIT     5
`define ADCSEQ_DIV_LSB      6
`define ADCSEQ_DIV_MSB      7

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define ADCSEQ_MD_ONESHOT   2'h0
`define ADCSEQ_MD_REPEAT    2'h1
`define ADCSEQ_MD_SWEEP     2'h2
`define ADCSEQ_MD_RSWEEP    2'h3
`define ADCSEQ_DIV_1        2'h0
`define ADCSEQ_DIV_2        2'h1
`define ADCSEQ_EXT_NONE     2'h0
`define ADCSEQ_EXT_A        2'h1
`define ADCSEQ_CH_EXT_A     4'h8
`define ADCSEQ_CH_EXT_B     4'h9
`define ADCSEQ_EVT_DONE     0
`define ADCSEQ_EVT_FINISH   1

// ----------------------------------------------------------------
// Conversion lengths in conversion-clock cycles
// ----------------------------------------------------------------
`define ADCSEQ_CYC_8_NOSH   6'd49
`define ADCSEQ_CYC_10_NOSH  6'd59
`define ADCSEQ_CYC_8_SH     6'd28
`define ADCSEQ_CYC_10_SH    6'd33

`endif

// ===== rtl/adcseq_conv.v
`timescale 1ns/1ns
`include "adcseq_consts.vh"
module adcseq_conv (
    input  wire mclk,     // System clock
    input  wire reset,    // Synchronous reset, high
    input  wire tick,     // Conversion clock enable pulse
    input  wire start,    // Start or restart a conversion
    input  wire abort,    // Drop a running conversion
    input  wire res10,    // 10-bit resolution
    input  wire sh_en,    // Sample and hold on
    output reg  busy,     // Conversion in progress
    output reg  done      // One-cycle end of conversion
);
    reg  [5:0] cnt_r;
    reg  [5:0] len;

    always @* begin
        case ({sh_en, res10})
            2'b00:   len = `ADCSEQ_CYC_8_NOSH;
            2'b01:   len = `ADCSEQ_CYC_10_NOSH;
            2'b10:   len = `ADCSEQ_CYC_8_SH;
            default: len = `ADCSEQ_CYC_10_SH;
        endcase
    end

    always @(posedge mclk) begin
        done <= 1'b0;
        if (reset || abort) begin
            busy  <= 1'b0;
            cnt_r <= 6'h00;
        end else if (start) begin
            // Restart wins over a finishing count
            busy  <= 1'b1;
            cnt_r <= 6'h00;
        end else if (busy && tick) begin
            if (cnt_r == len - 6'd1) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            cnt_r <= cnt_r + 6'd1;
        end
    end
endmodule // adcseq_conv

// ===== rtl/adcseq_top.v
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "adcseq_consts.vh"
module adcseq_top (
    input  wire        mclk,                // System clock, 125 MHz
    input  wire        reset,               // Synchronous reset, high
    input  wire        psel,                // APB select
    input  wire        penable,             // APB access phase
    input  wire        pwrite,              // APB write
    input  wire [7:0]  paddr,               // APB byte address
    input  wire [31:0] pwdata,              // APB write data
    output wire        pready,              // APB ready
    output reg  [31:0] prdata,              // APB read data
    output wire        pslverr,             // APB error, unmapped
    input  wire        ext_conv_trigger_in, // External trigger pin
    input  wire [9:0]  analog_code_in,      // Digitized analog core value
    output reg  [3:0]  analog_sel,          // Input mux select
    output reg         analog_sample,       // Sample strobe to core
    output wire        vref_connect,        // Ladder to reference
    output wire        irq                  // Level interrupt
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [2:0]  chan_sel_r;
    reg  [1:0]  mode_r;
    reg         trig_ext_r;
    reg         conversion_start_flag_r;
    reg         res10_r;
    reg         sh_r;
    reg         sweep1_r;
    reg  [1:0]  ext_sel_r;
    reg         vref_r;
    reg  [1:0]  div_r;
    reg  [1:0]  int_stat_r;
    reg  [1:0]  int_en_r;
    reg  [15:0] res_r [0:9];
    reg  [3:0]  cur_ch_r;
    reg  [2:0]  other_r;
    reg         trig_prev_r;
    reg  [1:0]  div_cnt_r;
    reg         running_r;

    integer     i;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    function is_res;
        input [7:0] a;
        begin
            is_res = (a >= `ADCSEQ_OFF_RES0) && (a[1:0] == 2'b00) &&
                     (a < `ADCSEQ_OFF_RES0 + {2'b00, `ADCSEQ_NUM_CH, 2'b00});
        end
    endfunction

    function [3:0] res_idx;
        input [7:0] a;
        reg   [7:0] d;
        begin
            d       = a - `ADCSEQ_OFF_RES0;
            res_idx = d[5:2];
        end
    endfunction

    wire mapped = (paddr == `ADCSEQ_OFF_CTRL0)    ||
                  (paddr == `ADCSEQ_OFF_CTRL1)    ||
                  (paddr == `ADCSEQ_OFF_STATUS)   ||
                  (paddr == `ADCSEQ_OFF_INT_STAT) ||
                  (paddr == `ADCSEQ_OFF_INT_CLR)  ||
                  (paddr == `ADCSEQ_OFF_INT_EN)   ||
                  is_res(paddr);

    wire acc    = psel && penable;
    wire wr     = acc && pwrite && mapped;
    wire wr_c0  = wr && (paddr == `ADCSEQ_OFF_CTRL0);
    wire wr_c1  = wr && (paddr == `ADCSEQ_OFF_CTRL1);
    wire wr_clr = wr && (paddr == `ADCSEQ_OFF_INT_CLR);
    wire wr_en  = wr && (paddr == `ADCSEQ_OFF_INT_EN);

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;

    // ----------------------------------------------------------------
    // Conversion clock
    // ----------------------------------------------------------------
    // Enable pulse rather than a derived clock keeps one domain
    always @(posedge mclk) begin
        if (reset)
            div_cnt_r <= 2'h0;
        else
            div_cnt_r <= div_cnt_r + 2'h1;
    end

    wire tick = (div_r == `ADCSEQ_DIV_1) ? 1'b1 :
                (div_r == `ADCSEQ_DIV_2) ? div_cnt_r[0] :
                (div_cnt_r == 2'h3);

    // ----------------------------------------------------------------
    // Start sources
    // ----------------------------------------------------------------
    wire st_wr    = wr_c0 && pwdata[`ADCSEQ_ST_BIT];
    wire sw_start = st_wr && !conversion_start_flag_r &&
                    !pwdata[`ADCSEQ_TRG_BIT];
    wire trig_fall = trig_prev_r && !ext_conv_trigger_in;
    wire ext_start = conversion_start_flag_r && trig_ext_r &&
                     trig_fall;
    wire stop_wr  = wr_c0 && !pwdata[`ADCSEQ_ST_BIT];

    always @(posedge mclk) begin
        if (reset)
            trig_prev_r <= 1'b1;
        else
            trig_prev_r <= ext_conv_trigger_in;
    end

    // First channel of a run; a start write brings its own channel
    wire [2:0] new_ch = sw_start ?
        pwdata[`ADCSEQ_CH_MSB:`ADCSEQ_CH_LSB] : chan_sel_r;
    wire [3:0] single_ch =
        (ext_sel_r == `ADCSEQ_EXT_NONE) ? {1'b0, new_ch} :
        (ext_sel_r == `ADCSEQ_EXT_A)    ? `ADCSEQ_CH_EXT_A :
                                          `ADCSEQ_CH_EXT_B;
    wire [1:0] new_mode = sw_start ?
        pwdata[`ADCSEQ_MD_MSB:`ADCSEQ_MD_LSB] : mode_r;
    wire [3:0] first_ch =
        (new_mode[1]) ? 4'h0 : single_ch;

    // ----------------------------------------------------------------
    // Conversion engine
    // ----------------------------------------------------------------
    wire conv_busy;
    wire conv_done;
    // Stop write beats a same-cycle trigger, else the run would hang
    wire go    = sw_start || (ext_start && !stop_wr);
    reg        chain;
    reg  [3:0] next_ch;
    reg  [2:0] next_other;
    reg        finish;

    adcseq_conv u_conv (
        .mclk  (mclk),
        .reset (reset),
        .tick  (tick),
        .start (go || chain),
        .abort (stop_wr),
        .res10 (res10_r),
        .sh_en (sh_r),
        .busy  (conv_busy),
        .done  (conv_done)
    );

    // Channel sequencing after each finished conversion
    always @* begin
        chain      = 1'b0;
        finish     = 1'b0;
        next_ch    = cur_ch_r;
        next_other = other_r;
        if (conv_done && running_r) begin
            case (mode_r)
                `ADCSEQ_MD_ONESHOT: begin
                    finish = 1'b1;
                end
                `ADCSEQ_MD_REPEAT: begin
                    chain = 1'b1;
                end
                `ADCSEQ_MD_SWEEP: begin
                    if (cur_ch_r[2:0] == chan_sel_r) begin
                        finish = 1'b1;
                    end else begin
                        chain   = 1'b1;
                        next_ch = cur_ch_r + 4'h1;
                    end
                end
                default: begin
                    chain = 1'b1;
                    if (!sweep1_r) begin
                        next_ch = (cur_ch_r[2:0] == chan_sel_r) ?
                                  4'h0 : cur_ch_r + 4'h1;
                    end else if (cur_ch_r != 4'h0) begin
                        // Channel zero between every other channel
                        next_ch = 4'h0;
                    end else begin
                        next_other = (other_r >= chan_sel_r) ?
                                     3'h1 : other_r + 3'h1;
                        next_ch    = {1'b0, next_other};
                    end
                end
            endcase
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            cur_ch_r      <= 4'h0;
            other_r       <= 3'h0;
            running_r     <= 1'b0;
            analog_sel    <= 4'h0;
            analog_sample <= 1'b0;
        end else begin
            analog_sample <= go || chain;
            if (go) begin
                cur_ch_r   <= first_ch;
                other_r    <= 3'h0;
                running_r  <= 1'b1;
                analog_sel <= first_ch;
            end else if (stop_wr || finish) begin
                running_r  <= 1'b0;
            end else if (chain) begin
                cur_ch_r   <= next_ch;
                other_r    <= next_other;
                analog_sel <= next_ch;
            end
        end
    end

    // ----------------------------------------------------------------
    // Results
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            for (i = 0; i < `ADCSEQ_NUM_CH; i = i + 1)
                res_r[i] <= 16'h0000;
        end else if (conv_done && running_r) begin
            if (res10_r)
                res_r[cur_ch_r] <= {6'h00, analog_code_in};
            else
                res_r[cur_ch_r] <= {8'h00, analog_code_in[9:2]};
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            chan_sel_r              <= 3'h0;
            mode_r                  <= 2'h0;
            trig_ext_r              <= 1'b0;
            conversion_start_flag_r <= 1'b0;
            res10_r                 <= 1'b0;
            sh_r                    <= 1'b0;
            sweep1_r                <= 1'b0;
            ext_sel_r               <= 2'h0;
            vref_r                  <= 1'b0;
            div_r                   <= 2'h0;
            int_en_r                <= 2'h0;
        end else begin
            if (wr_c0) begin
                chan_sel_r <= pwdata[`ADCSEQ_CH_MSB:`ADCSEQ_CH_LSB];
                mode_r     <= pwdata[`ADCSEQ_MD_MSB:`ADCSEQ_MD_LSB];
                trig_ext_r <= pwdata[`ADCSEQ_TRG_BIT];
            end
            // Software write beats the hardware clear
            if (wr_c0)
                conversion_start_flag_r <= pwdata[`ADCSEQ_ST_BIT];
            else if (finish)
                conversion_start_flag_r <= 1'b0;
            if (wr_c1) begin
                res10_r   <= pwdata[`ADCSEQ_RES10_BIT];
                sh_r      <= pwdata[`ADCSEQ_SH_BIT];
                sweep1_r  <= pwdata[`ADCSEQ_SWP1_BIT];
                ext_sel_r <= pwdata[`ADCSEQ_EXT_MSB:`ADCSEQ_EXT_LSB];
                vref_r    <= pwdata[`ADCSEQ_VREF_BIT];
                div_r     <= pwdata[`ADCSEQ_DIV_MSB:`ADCSEQ_DIV_LSB];
            end
            if (wr_en)
                int_en_r <= pwdata[1:0];
        end
    end

    // Cleared ladder bit isolates the reference, running or idle
    assign vref_connect = vref_r;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    wire [1:0] evt;
    assign evt[`ADCSEQ_EVT_DONE]   = conv_done && running_r;
    assign evt[`ADCSEQ_EVT_FINISH] = finish;

    always @(posedge mclk) begin
        if (reset)
            int_stat_r <= 2'h0;
        else
            // New event wins over a same-cycle clear
            int_stat_r <= (int_stat_r & ~(wr_clr ? pwdata[1:0] : 2'h0)) |
                          evt;
    end

    assign irq = |(int_stat_r & int_en_r);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `ADCSEQ_OFF_CTRL0:
                    prdata <= {25'h000_0000, conversion_start_flag_r,
                               trig_ext_r, mode_r, chan_sel_r};
                `ADCSEQ_OFF_CTRL1:
                    prdata <= {24'h00_0000, div_r, vref_r, ext_sel_r,
                               sweep1_r, sh_r, res10_r};
                `ADCSEQ_OFF_STATUS:
                    prdata <= {26'h000_0000, running_r, conv_busy,
                               cur_ch_r};
                `ADCSEQ_OFF_INT_STAT:
                    prdata <= {30'h0000_0000, int_stat_r};
                `ADCSEQ_OFF_INT_EN:
                    prdata <= {30'h0000_0000, int_en_r};
                default:
                    prdata <= is_res(paddr) ?
                              {16'h0000, res_r[res_idx(paddr)]} :
                              32'h0000_0000;
            endcase
        end
    end
endmodule // adcseq_top

// ===== sim/adcseq_analog_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Analog inputs and external trigger source
// ------------------------------------------------------------
module adcseq_analog_model (
    input  wire       mclk, // System clock
    input  wire [3:0] sel,  // Mux select from the block
    input  wire [5:0] salt, // Low code bits chosen by the bench
    input  wire       fire, // Request one trigger pulse
    output wire [9:0] code, // Digitized value of the selected input
    output reg        trig  // Trigger pin, idles high
);
    reg [1:0] low_cnt_r = 2'h0;
    // Upper bits name the input, so a wrong mux shows in the result
    assign code = {sel, salt};
    always @(posedge mclk) begin
        if (fire)
            low_cnt_r <= 2'h2;
        else if (low_cnt_r != 2'h0)
            low_cnt_r <= low_cnt_r - 2'h1;
        trig <= !(fire || low_cnt_r != 2'h0);
    end
endmodule // adcseq_analog_model

// ===== sim/adcseq_asserts.sv
`timescale 1ns/1ns
`include "adcseq_consts.vh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module adcseq_asserts (
    input wire        mclk,                // Clock
    input wire        reset,               // Reset
    input wire        psel,                // APB select
    input wire        penable,             // APB enable
    input wire        pwrite,              // APB write
    input wire [7:0]  paddr,               // APB address
    input wire [31:0] pwdata,              // APB write data
    input wire        pready,              // APB ready
    input wire [31:0] prdata,              // APB read data
    input wire        pslverr,             // APB error
    input wire        ext_conv_trigger_in, // Trigger pin
    input wire [9:0]  analog_code_in,      // Analog code
    input wire [3:0]  analog_sel,          // Mux select
    input wire        analog_sample,       // Sample strobe
    input wire        vref_connect,        // Ladder connect
    input wire        irq                  // Interrupt
);
    wire acc = psel && penable;
    wire c1_wr = acc && pwrite && paddr == `ADCSEQ_OFF_CTRL1;
    wire en_wr = acc && pwrite && paddr == `ADCSEQ_OFF_INT_EN;
    property p_ready;
        @(posedge mclk) disable iff (reset) pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err;
        @(posedge mclk) disable iff (reset) pslverr |-> acc;
    endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
    property p_err_rd;
        @(posedge mclk) disable iff (reset)
            acc && !pwrite && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_err_rd: assert property (p_err_rd) else $error("unmapped read not 0");
    property p_vref_wr;
        @(posedge mclk) disable iff (reset)
            c1_wr |=> vref_connect == $past(pwdata[`ADCSEQ_VREF_BIT]);
    endproperty
    a_vref_wr: assert property (p_vref_wr) else $error("ladder bit");
    property p_vref_hold;
        @(posedge mclk) disable iff (reset) !c1_wr |=> $stable(vref_connect);
    endproperty
    a_vref_hold: assert property (p_vref_hold) else $error("ladder moved");
    property p_sel;
        @(posedge mclk) disable iff (reset) analog_sel <= 4'h9;
    endproperty
    a_sel: assert property (p_sel) else $error("select out of range");
    property p_samp;
        @(posedge mclk) disable iff (reset) analog_sample |=> !analog_sample;
    endproperty
    a_samp: assert property (p_samp) else $error("sample too long");
    property p_mask;
        @(posedge mclk) disable iff (reset)
            en_wr && pwdata == 32'h0000_0000 |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq high");
    property p_rst;
        @(posedge mclk) reset |=> prdata == 32'h0000_0000 && !irq
            && !vref_connect && analog_sel == 4'h0 && !analog_sample;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values");
endmodule // adcseq_asserts

bind adcseq_top adcseq_asserts u_chk (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_conv_trigger_in(ext_conv_trigger_in),
    .analog_code_in(analog_code_in), .analog_sel(analog_sel),
    .analog_sample(analog_sample), .vref_connect(vref_connect), .irq(irq));

// ===== sim/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ns
`include "adcseq_consts.vh"
`define CHK(a, e) begin checks = checks + 1; if ((a) !== (e)) begin \
    n_mismatch = n_mismatch + 1; \
    $display("Error at %0t got %h exp %h", $time, (a), (e)); end end
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module adc_conversion_sequencer_tb;
    reg         mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    reg         fire = 0, rerr;
    reg  [7:0]  paddr = 0;
    reg  [31:0] pwdata = 0, rdat;
    reg  [5:0]  salt = 0;
    wire        pready, pslverr, trig, vref, irq, samp;
    wire [31:0] prdata;
    wire [9:0]  code;
    wire [3:0]  asel;
    integer     n_mismatch = 0, checks = 0, cyc = 0, n, i;
    adcseq_top uut (.mclk(mclk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_conv_trigger_in(trig), .analog_code_in(code),
        .analog_sel(asel), .analog_sample(samp), .vref_connect(vref),
        .irq(irq));
    adcseq_analog_model u_ana (.mclk(mclk), .sel(asel), .salt(salt),
        .fire(fire), .code(code), .trig(trig));
    always #4 mclk = ~mclk;
    // Whole run is under two thousand cycles; the ceiling catches hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
    task end_of_test;
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task wr(input [7:0] a, input [31:0] d); apb(1'b1, a, d); endtask
    task rd(input [7:0] a); apb(1'b0, a, 32'h0000_0000); endtask
    task wait_irq;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n = n + 1;
        end
    endtask
    task t_reset;
        rd(`ADCSEQ_OFF_CTRL0); `CHK(rdat, 32'h0000_0000)
        rd(`ADCSEQ_OFF_INT_STAT); `CHK(rdat, 32'h0000_0000)
        rd(8'h0c); `CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
        wr(8'h0c, 32'hffff_ffff); `CHK(rerr, 1'b1)
        `CHK({irq, vref}, 2'b00)
        wr(`ADCSEQ_OFF_CTRL1, 32'h0000_0020);
        @(posedge mclk);
        `CHK(vref, 1'b1)
    endtask
    // One-shot run: length, result placement, flag clear and interrupt
    task one_shot(input [31:0] c1, input [3:0] ch, input [3:0] rch,
                  input integer len, input integer tol);
        reg [9:0] e;
        salt <= salt + 6'h0b;
        wr(`ADCSEQ_OFF_CTRL1, c1);
        wr(`ADCSEQ_OFF_INT_CLR, 32'h0000_0003);
        wr(`ADCSEQ_OFF_INT_EN, 32'h0000_0001);
        wr(`ADCSEQ_OFF_CTRL0, 32'h0000_0040 | ch);
        @(posedge mclk);
        `CHK({samp, asel}, {1'b1, rch})
        wait_irq;
        `CHK(n >= len && n <= len + tol, 1'b1)
        e = {rch, salt};
        rd(`ADCSEQ_OFF_RES0 + {rch, 2'b00});
        `CHK(rdat, c1[0] ? {22'h0, e} : {24'h0, e[9:2]})
        rd(`ADCSEQ_OFF_CTRL0); `CHK(rdat[6], 1'b0)
        rd(`ADCSEQ_OFF_INT_STAT); `CHK(rdat, 32'h0000_0003)
        wr(`ADCSEQ_OFF_INT_EN, 32'h0000_0000);
        @(posedge mclk);
        `CHK(irq, 1'b0)
        wr(`ADCSEQ_OFF_INT_CLR, 32'h0000_0003);
        rd(`ADCSEQ_OFF_INT_STAT); `CHK(rdat, 32'h0000_0000)
    endtask
    task t_ext;
        salt <= 6'h2d;
        wr(`ADCSEQ_OFF_CTRL1, 32'h0000_0021);
        wr(`ADCSEQ_OFF_INT_EN, 32'h0000_0001);
        wr(`ADCSEQ_OFF_CTRL0, 32'h0000_0064);
        repeat (80) @(posedge mclk);
        `CHK(irq, 1'b0)
        fire <= 1;
        @(posedge mclk) fire <= 0;
        repeat (30) @(posedge mclk);
        fire <= 1;
        @(posedge mclk) fire <= 0;
        wait_irq;
        `CHK(n >= 59 && n <= 65, 1'b1)
        rd(`ADCSEQ_OFF_RES0 + 8'h10); `CHK(rdat, {22'h0, 4'h4, 6'h2d})
        wr(`ADCSEQ_OFF_INT_CLR, 32'h0000_0003);
    endtask
    // Repeating modes keep the flag up and keep converting
    task t_repeat(input [31:0] c1, input [31:0] c0);
        salt <= salt + 6'h07;
        wr(`ADCSEQ_OFF_CTRL1, c1);
        wr(`ADCSEQ_OFF_CTRL0, c0);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`ADCSEQ_OFF_INT_CLR, 32'h0000_0003);
            @(posedge mclk);
            wait_irq;
            `CHK(irq, 1'b1)
        end
        rd(`ADCSEQ_OFF_CTRL0); `CHK(rdat[6], 1'b1)
        rd(`ADCSEQ_OFF_INT_STAT); `CHK(rdat[1], 1'b0)
        wr(`ADCSEQ_OFF_CTRL0, 32'h0000_0000);
        rd(`ADCSEQ_OFF_RES0 + 8'h04); `CHK(rdat, {22'h0, 4'h1, salt})
    endtask
    task t_sweep;
        salt <= 6'h19;
        wr(`ADCSEQ_OFF_CTRL1, 32'h0000_0023);
        wr(`ADCSEQ_OFF_INT_CLR, 32'h0000_0003);
        wr(`ADCSEQ_OFF_INT_EN, 32'h0000_0002);
        wr(`ADCSEQ_OFF_CTRL0, 32'h0000_0052);
        wait_irq;
        `CHK(irq, 1'b1)
        for (i = 0; i < 3; i = i + 1) begin
            rd(`ADCSEQ_OFF_RES0 + 4 * i);
            `CHK(rdat, {22'h0, i[3:0], 6'h19})
        end
        rd(`ADCSEQ_OFF_CTRL0); `CHK(rdat[6], 1'b0)
        wr(`ADCSEQ_OFF_INT_CLR, 32'h0000_0003);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 0;
        t_reset;
        for (i = 0; i < 4; i = i + 1)
            one_shot(32'h20 | i, i + 3, i + 3, i[1] ? (i[0] ? 33 : 28)
                     : (i[0] ? 59 : 49), 3);
        one_shot(32'h0000_0062, 4'h7, 4'h7, 56, 7);
        one_shot(32'h0000_00a2, 4'h6, 4'h6, 110, 7);
        one_shot(32'h0000_00e2, 4'h6, 4'h6, 110, 7);
        one_shot(32'h0000_0028, 4'h0, 4'h8, 49, 3);
        one_shot(32'h0000_0033, 4'h0, 4'h9, 33, 3);
        t_ext;
        wr(`ADCSEQ_OFF_INT_EN, 32'h0000_0001);
        t_repeat(32'h0000_0023, 32'h0000_0049);
        t_repeat(32'h0000_0023, 32'h0000_0059);
        t_repeat(32'h0000_0027, 32'h0000_0059);
        t_sweep;
        end_of_test;
    end
endmodule // adc_conversion_sequencer_tb
